/* File: core/pcsd_pkg.sv */
// Package for the peripheral clock select and divide block.
// Assumes byte addresses relative to the block base and a 32-bit Wishbone bus.
package pcsd_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int CTL_N  = 11;   // Masked select/divide registers
    localparam int FRAC_N = 6;    // Fractional ratio registers
    localparam int CH_N   = 12;   // Integer dividers
    localparam int CNT_W  = 10;   // Widest divisor field

    // ------------------------------------------------------------------
    // Register map, index 0 in the low slot
    // ------------------------------------------------------------------
    // 0 audio1, 1 audio2, 2 dig audio out, 3..5 serial0..2,
    // 6 mic+crypto, 7 transport stream, 8 thermal adc, 9 approx adc, 10 pwm
    localparam logic [CTL_N-1:0][11:0] CTL_OFS = {
        12'h160, 12'h15c, 12'h158, 12'h154, 12'h150, 12'h148,
        12'h140, 12'h138, 12'h130, 12'h128, 12'h120};
    localparam logic [CTL_N-1:0][15:0] CTL_RST = {
        16'h0700, 16'h01e0, 16'h01e0, 16'h0400, 16'h8f04, 16'h0007,
        16'h0007, 16'h0007, 16'h000f, 16'h000f, 16'h000f};
    // Bits that hold state; all others are reserved
    localparam logic [CTL_N-1:0][15:0] CTL_WMASK = {
        16'hff00, 16'h03ff, 16'h03ff, 16'h9f00, 16'hdf9f, 16'h337f,
        16'h337f, 16'h337f, 16'h837f, 16'h937f, 16'h937f};
    // 0 audio1, 1 audio2, 2 dig audio out, 3..5 serial0..2
    localparam logic [FRAC_N-1:0][11:0] FRAC_OFS = {
        12'h14c, 12'h144, 12'h13c, 12'h134, 12'h12c, 12'h124};
    localparam logic [31:0] FRAC_RST = 32'h0bb8ea60;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int MASK_LSB       = 16;  // Write-enable half
    localparam int SRC_BIT        = 15;  // One-bit loop pick, upper
    localparam int CRYPTO_SRC_BIT = 7;   // One-bit loop pick, lower
    localparam int OUT_PICK_BIT   = 12;  // Audio output pick
    localparam int CLK_PICK_LSB   = 8;   // Two-bit clock pick
    localparam int SERIAL_SRC_LSB = 12;  // Serial port loop pick
    localparam int MIC_SRC_LSB    = 14;  // Microphone loop pick
    localparam int MID_DIV_LSB    = 8;   // Divisor in upper byte
    localparam int WIDE_DIV_W     = 7;
    localparam int NARROW_DIV_W   = 5;
    localparam int ADC_DIV_W      = 10;
    localparam int NUM_LSB        = 16;  // Numerator half of a ratio

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] PICK_INT  = 2'h0;
    localparam logic [1:0] PICK_FRAC = 2'h1;
    localparam logic [1:0] PICK_PIN  = 2'h2;
    localparam logic [1:0] SRC_CODEC = 2'h0;
    localparam logic [1:0] SRC_GEN   = 2'h1;
    localparam logic [1:0] SRC_THIRD = 2'h2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic codec_loop;
        logic general_loop;
        logic processor_loop;
        logic usb_phy_480m;
        logic osc_24m;
        logic ref_12m;
        logic audio1_pin;
        logic audio2_pin;
    } pcsd_src_t;

    typedef struct packed {
        logic audio_serial1;
        logic audio_serial2;
        logic digital_audio_out;
        logic [2:0] serial_port;
        logic mic;
        logic crypto;
        logic transport_stream;
        logic thermal_adc;
        logic approx_adc;
        logic pulse_width;
    } pcsd_clk_out_t;

endpackage : pcsd_pkg

/* File: core/pcsd_top.sv */
// Peripheral clock select and divide: register file plus tick-based dividers.
// Assumes every source clock arrives as a one-cycle tick synchronous to
// clock; each generated clock leaves as a one-cycle tick per output edge.
//
// Chosen here: the Wishbone slave port.

// Operation
// - Masked registers change a low bit only where its upper mask bit is one.
// - Integer divider output equals source divided by divisor plus one.
// - Ratio registers hold numerator high, denominator low, reset 0x0bb8ea60.
// - Audio port one divisor is bits 6:0, reset fifteen.
// - Audio port two source bit: zero codec loop, one general loop.
// - Audio port two pick: integer, fractional, pin clock, 12 MHz.
// - Audio port two output bit: own clock at zero, 12 MHz at one.
// - Audio port two divisor bits 6:0 reset fifteen; ratio at 0x12c.
// - Digital audio pick: integer, fractional, else 12 MHz; source bit too.
// - Digital audio ratio is a plain 32-bit register, no mask.
// - Serial port source: codec, general, or USB 480 MHz clock.
// - Serial port pick: integer, fractional, else 24 MHz oscillator.
// - Serial port divisors are bits 6:0, reset seven.
// - Microphone source: codec, general, processor loop; reset processor.
// - Microphone divisor is bits 12:8, reset fifteen.
// - Crypto source bit seven, divisor bits 4:0 reset four.
// - Transport stream source bit fifteen, divisor bits 12:8 reset four.
// - Thermal converter divisor bits 9:0, reset 0x1e0.
// - Approx converter divisor bits 9:0, reset 0x1e0, at 0x15c.
// - Pulse-width source bit fifteen, divisor bits 14:8 reset seven.
// - Audio port one pick: integer, fractional, pin clock, 12 MHz.
// - Audio port one source bit: zero codec loop, one general loop.
module pcsd_top #(
    parameter int ADR_W = 12
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [ADR_W-1:0]       wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire pcsd_pkg::pcsd_src_t    src_tick,
    output pcsd_pkg::pcsd_clk_out_t     clk_tick
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (ADR_W < 9 || ADR_W > 12) begin : g_adr_check
        $error("pcsd_top: ADR_W must lie between 9 and 12");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [pcsd_pkg::CTL_N-1:0][15:0]              ctl;
        logic [pcsd_pkg::FRAC_N-1:0][31:0]             frac;
        logic [pcsd_pkg::CH_N-1:0][pcsd_pkg::CNT_W-1:0] cnt;
        logic [pcsd_pkg::CH_N-1:0]                     itick;
        logic [pcsd_pkg::FRAC_N-1:0][15:0]             acc;
        logic [pcsd_pkg::FRAC_N-1:0]                   ftick;
        pcsd_pkg::pcsd_clk_out_t                       out;
        logic                                          ack;
        logic [31:0]                                   rdat;
    } pcsd_state_t;

    pcsd_state_t s_q;
    pcsd_state_t s_d;

    // Combinational helpers
    logic                                          req;
    logic                                          wr;
    logic [11:0]                                   adr12;
    logic [31:0]                                   lane;
    logic [31:0]                                   wdat;
    logic [15:0]                                   wmask;
    logic [31:0]                                   rd;
    logic [pcsd_pkg::CH_N-1:0]                     ch_src;
    logic [pcsd_pkg::CH_N-1:0][pcsd_pkg::CNT_W-1:0] ch_div;
    logic [16:0]                                   sum;
    logic [15:0]                                   num;
    logic [15:0]                                   den;
    logic [15:0]                                   rest;
    logic                                          gen1;
    logic                                          gen2;

    // Source pick for the one-bit loop fields
    function automatic logic loop2(input logic sel, input pcsd_pkg::pcsd_src_t s);
        return sel ? s.general_loop : s.codec_loop;
    endfunction : loop2

    // Source pick for the two-bit loop fields
    function automatic logic loop3(input logic [1:0] sel, input logic third,
                                   input pcsd_pkg::pcsd_src_t s);
        logic r;
        r = 1'b0;
        if (sel == pcsd_pkg::SRC_CODEC) begin
            r = s.codec_loop;
        end else if (sel == pcsd_pkg::SRC_GEN) begin
            r = s.general_loop;
        end else if (sel == pcsd_pkg::SRC_THIRD) begin
            r = third;
        end
        return r;
    endfunction : loop3

    // Two-bit clock pick of the audio and serial ports
    function automatic logic pick4(input logic [1:0] sel, input logic i_t,
                                   input logic f_t, input logic p_t,
                                   input logic fixed_t);
        logic r;
        case (sel)
            pcsd_pkg::PICK_INT:  r = i_t;
            pcsd_pkg::PICK_FRAC: r = f_t;
            pcsd_pkg::PICK_PIN:  r = p_t;
            default:             r = fixed_t;
        endcase
        return r;
    endfunction : pick4

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d   = s_q;
        req   = wb_cyc_i & wb_stb_i;
        wr    = req & wb_we_i & s_q.ack;  // Write lands on the acked edge
        adr12 = 12'(wb_adr_i);
        rd    = 32'h0;
        wmask = 16'h0;
        sum   = 17'h0;
        num   = 16'h0;
        den   = 16'h0;
        rest  = 16'h0;
        for (int b = 0; b < 4; b++) begin
            lane[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
        wdat = wb_dat_i & lane;

        // Bus answer one cycle after the request, dropped the next cycle
        s_d.ack = req & ~s_q.ack;

        // Masked control registers
        for (int i = 0; i < pcsd_pkg::CTL_N; i++) begin
            if (adr12[11:2] == pcsd_pkg::CTL_OFS[i][11:2]) begin
                rd = {16'h0, s_q.ctl[i] & pcsd_pkg::CTL_WMASK[i]};
                if (wr) begin
                    wmask = wdat[pcsd_pkg::MASK_LSB +: 16] & pcsd_pkg::CTL_WMASK[i];
                    s_d.ctl[i] = (s_q.ctl[i] & ~wmask) | (wdat[15:0] & wmask);
                end
            end
        end

        // Plain fractional ratio registers, byte lanes honoured
        for (int f = 0; f < pcsd_pkg::FRAC_N; f++) begin
            if (adr12[11:2] == pcsd_pkg::FRAC_OFS[f][11:2]) begin
                rd = s_q.frac[f];
                if (wr) begin
                    s_d.frac[f] = (s_q.frac[f] & ~lane) | wdat;
                end
            end
        end

        // Read data latched together with the answer; unmapped reads zero
        if (req & ~s_q.ack) begin
            s_d.rdat = rd;
        end

        // Source and divisor of each integer divider
        ch_src[0]  = loop2(s_q.ctl[0][pcsd_pkg::SRC_BIT], src_tick);
        ch_div[0]  = pcsd_pkg::CNT_W'(s_q.ctl[0][pcsd_pkg::WIDE_DIV_W-1:0]);
        ch_src[1]  = loop2(s_q.ctl[1][pcsd_pkg::SRC_BIT], src_tick);
        ch_div[1]  = pcsd_pkg::CNT_W'(s_q.ctl[1][pcsd_pkg::WIDE_DIV_W-1:0]);
        ch_src[2]  = loop2(s_q.ctl[2][pcsd_pkg::SRC_BIT], src_tick);
        ch_div[2]  = pcsd_pkg::CNT_W'(s_q.ctl[2][pcsd_pkg::WIDE_DIV_W-1:0]);
        for (int u = 0; u < 3; u++) begin
            ch_src[3+u] = loop3(s_q.ctl[3+u][pcsd_pkg::SERIAL_SRC_LSB +: 2],
                                src_tick.usb_phy_480m, src_tick);
            ch_div[3+u] = pcsd_pkg::CNT_W'(
                s_q.ctl[3+u][pcsd_pkg::WIDE_DIV_W-1:0]);
        end
        ch_src[6]  = loop3(s_q.ctl[6][pcsd_pkg::MIC_SRC_LSB +: 2],
                           src_tick.processor_loop, src_tick);
        ch_div[6]  = pcsd_pkg::CNT_W'(
            s_q.ctl[6][pcsd_pkg::MID_DIV_LSB +: pcsd_pkg::NARROW_DIV_W]);
        ch_src[7]  = loop2(s_q.ctl[6][pcsd_pkg::CRYPTO_SRC_BIT], src_tick);
        ch_div[7]  = pcsd_pkg::CNT_W'(s_q.ctl[6][pcsd_pkg::NARROW_DIV_W-1:0]);
        ch_src[8]  = loop2(s_q.ctl[7][pcsd_pkg::SRC_BIT], src_tick);
        ch_div[8]  = pcsd_pkg::CNT_W'(
            s_q.ctl[7][pcsd_pkg::MID_DIV_LSB +: pcsd_pkg::NARROW_DIV_W]);
        ch_src[9]  = src_tick.osc_24m;
        ch_div[9]  = s_q.ctl[8][pcsd_pkg::ADC_DIV_W-1:0];
        ch_src[10] = src_tick.osc_24m;
        ch_div[10] = s_q.ctl[9][pcsd_pkg::ADC_DIV_W-1:0];
        ch_src[11] = loop2(s_q.ctl[10][pcsd_pkg::SRC_BIT], src_tick);
        ch_div[11] = pcsd_pkg::CNT_W'(
            s_q.ctl[10][pcsd_pkg::MID_DIV_LSB +: pcsd_pkg::WIDE_DIV_W]);

        // Integer dividers: one output tick per divisor+1 source ticks
        for (int c = 0; c < pcsd_pkg::CH_N; c++) begin
            s_d.itick[c] = 1'b0;
            if (ch_src[c]) begin
                if (s_q.cnt[c] >= ch_div[c]) begin
                    s_d.cnt[c]   = '0;
                    s_d.itick[c] = 1'b1;
                end else begin
                    s_d.cnt[c] = s_q.cnt[c] + 1'b1;
                end
            end
        end

        // Fractional dividers fed by the integer divider output
        for (int f = 0; f < pcsd_pkg::FRAC_N; f++) begin
            num          = s_q.frac[f][pcsd_pkg::NUM_LSB +: 16];
            den          = s_q.frac[f][15:0];
            s_d.ftick[f] = 1'b0;
            if (s_q.itick[f] && den != 16'h0) begin
                sum = {1'b0, s_q.acc[f]} + {1'b0, num};
                if (sum >= {1'b0, den}) begin
                    rest         = 16'(sum - {1'b0, den});
                    s_d.acc[f]   = (rest >= den) ? 16'h0 : rest;
                    s_d.ftick[f] = 1'b1;
                end else begin
                    s_d.acc[f] = sum[15:0];
                end
            end
        end

        // Output picks; whole-cycle ticks, so a switch cannot make a runt
        gen1 = pick4(s_q.ctl[0][pcsd_pkg::CLK_PICK_LSB +: 2], s_q.itick[0],
                     s_q.ftick[0], src_tick.audio1_pin, src_tick.ref_12m);
        gen2 = pick4(s_q.ctl[1][pcsd_pkg::CLK_PICK_LSB +: 2], s_q.itick[1],
                     s_q.ftick[1], src_tick.audio2_pin, src_tick.ref_12m);
        s_d.out.audio_serial1 = s_q.ctl[0][pcsd_pkg::OUT_PICK_BIT] ?
                                src_tick.ref_12m : gen1;
        s_d.out.audio_serial2 = s_q.ctl[1][pcsd_pkg::OUT_PICK_BIT] ?
                                src_tick.ref_12m : gen2;
        s_d.out.digital_audio_out = pick4(s_q.ctl[2][pcsd_pkg::CLK_PICK_LSB +: 2],
            s_q.itick[2], s_q.ftick[2], src_tick.ref_12m, src_tick.ref_12m);
        for (int u = 0; u < 3; u++) begin
            s_d.out.serial_port[u] = pick4(
                s_q.ctl[3+u][pcsd_pkg::CLK_PICK_LSB +: 2], s_q.itick[3+u],
                s_q.ftick[3+u], src_tick.osc_24m, src_tick.osc_24m);
        end
        s_d.out.mic              = s_q.itick[6];
        s_d.out.crypto           = s_q.itick[7];
        s_d.out.transport_stream = s_q.itick[8];
        s_d.out.thermal_adc      = s_q.itick[9];
        s_d.out.approx_adc       = s_q.itick[10];
        s_d.out.pulse_width      = s_q.itick[11];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q       <= '0;
            s_q.ctl   <= pcsd_pkg::CTL_RST;
            s_q.frac  <= {pcsd_pkg::FRAC_N{pcsd_pkg::FRAC_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs straight from the state register
    // ------------------------------------------------------------------
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign clk_tick = s_q.out;

endmodule : pcsd_top

/* File: bench/pcsd_top_sva.sv */
// Checker for pcsd_top: register bus handshake, read-back zeros, quiet outputs.
// Assumes it sees only the top ports and is attached by the bind below.
module pcsd_top_sva #(
    parameter int ADR_W = 12
) (
    input wire logic                    clock,
    input wire logic                    rst,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [ADR_W-1:0]        wb_adr_i,
    input wire logic [3:0]              wb_sel_i,
    input wire logic [31:0]             wb_dat_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    input wire pcsd_pkg::pcsd_src_t     src_tick,
    input wire pcsd_pkg::pcsd_clk_out_t clk_tick
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    logic        req;
    logic        rd_ack;
    logic [11:0] a;
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign a      = 12'(wb_adr_i);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers_req: assert property (req |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_mask_half_zero: assert property (rd_ack && a inside {12'h120, 12'h128, 12'h130,
        12'h138, 12'h140, 12'h148, 12'h150, 12'h154, 12'h158, 12'h15c, 12'h160}
        |-> wb_dat_o[31:16] == 16'h0000)
        else $error("mask half reads nonzero");
    a_unmapped_zero: assert property (rd_ack && a == 12'h100 |-> wb_dat_o == 32'h0)
        else $error("unmapped read nonzero");
    a_stream_resv_zero: assert property (rd_ack && a == 12'h154
        |-> wb_dat_o[7:0] == 8'h00 && wb_dat_o[14:13] == 2'h0)
        else $error("stream reserved bits nonzero");
    a_adc_resv_zero: assert property (rd_ack && a inside {12'h158, 12'h15c}
        |-> wb_dat_o[31:10] == 22'h0)
        else $error("converter reserved bits nonzero");
    a_serial_resv_zero: assert property (rd_ack && a inside {12'h138, 12'h140, 12'h148}
        |-> wb_dat_o[15:14] == 2'h0 && wb_dat_o[11:10] == 2'h0 && !wb_dat_o[7])
        else $error("serial reserved bits nonzero");
    a_quiet_no_tick: assert property ($past(src_tick, 1) == '0 && $past(src_tick, 2) == '0
        && $past(src_tick, 3) == '0 |-> clk_tick == '0)
        else $error("output tick without source tick");

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    c_masked_read: cover property (rd_ack && a == 12'h128);
    c_write: cover property (wb_ack_o && wb_we_i);
    c_audio_tick: cover property (clk_tick.audio_serial2);
endmodule : pcsd_top_sva

bind pcsd_top pcsd_top_sva #(.ADR_W(ADR_W)) u_sva (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_tick(src_tick), .clk_tick(clk_tick));

/* File: bench/pcsd_top_bench.sv */
// Testbench for pcsd_top: register reset values, masked writes, tick counts.
// Assumes the package and design are compiled before this file.
module pcsd_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clock;
    logic                    rst;
    logic                    wb_cyc_i;
    logic                    wb_stb_i;
    logic                    wb_we_i;
    logic                    wb_ack_o;
    logic [11:0]             wb_adr_i;
    logic [3:0]              wb_sel_i;
    logic [31:0]             wb_dat_i;
    logic [31:0]             wb_dat_o;
    logic [31:0]             rd;
    pcsd_pkg::pcsd_src_t     src_tick;
    pcsd_pkg::pcsd_clk_out_t clk_tick;
    int                      n_fail;
    int                      n_tests;
    int                      mon_idx;
    int                      mon_cnt;

    pcsd_top dut (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_tick(src_tick), .clk_tick(clk_tick));

    // Clock and output tick counter
    always #5 clock = ~clock;
    always @(negedge clock) begin
        if (clk_tick[mon_idx] === 1'b1) begin
            mon_cnt = mon_cnt + 1;
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // One classic Wishbone cycle; read data lands in rd
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd);
        int i;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(negedge clock);
        if (i == 20) begin
            n_fail++;
            $display("Error at %0t: bus timeout", $time);
            finish_test();
        end
        @(posedge clock);
        rd = wb_dat_o;  // Taken at the edge that sees ack high
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp, input string what);
        wb(1'b0, adr, 32'h0);
        check(rd, exp, what);
    endtask : rd_chk

    // Pulse one source n times, count one output
    task automatic pulse(input int sb, input int ob, input int n, input logic [31:0] exp,
                         input string what);
        int i;
        mon_idx = ob;
        mon_cnt = 0;
        for (i = 0; i < n; i++) begin
            @(posedge clock);
            src_tick <= pcsd_pkg::pcsd_src_t'(8'h01 << sb);
            @(posedge clock);
            src_tick <= '0;
        end
        repeat (6) @(posedge clock);
        check(32'(mon_cnt), exp, what);
    endtask : pulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [11:0] ad [18] = '{12'h120, 12'h124, 12'h128, 12'h12c, 12'h130, 12'h134,
            12'h138, 12'h13c, 12'h140, 12'h144, 12'h148, 12'h14c, 12'h150, 12'h154,
            12'h158, 12'h15c, 12'h160, 12'h100};
        logic [31:0] ex [18] = '{32'h0f, 32'h0bb8ea60, 32'h0f, 32'h0bb8ea60, 32'h0f,
            32'h0bb8ea60, 32'h07, 32'h0bb8ea60, 32'h07, 32'h0bb8ea60, 32'h07, 32'h0bb8ea60,
            32'h8f04, 32'h0400, 32'h01e0, 32'h01e0, 32'h0700, 32'h0};
        for (int i = 0; i < 18; i++) begin
            rd_chk(ad[i], ex[i], "reset value");
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_mask;
        wb(1'b1, 12'h128, 32'h0000_007f);
        rd_chk(12'h128, 32'h0f, "unmasked write");
        wb(1'b1, 12'h128, 32'h0083_0085);
        rd_chk(12'h128, 32'h0d, "masked write");
        wb(1'b1, 12'h134, 32'h1234_5678);
        rd_chk(12'h134, 32'h1234_5678, "plain ratio");
        $display("test mask done");
    endtask : t_mask

    task automatic t_audio2;
        wb(1'b1, 12'h128, 32'h937f_0003);
        pulse(6, 10, 40, 32'd0, "codec pick");
        wb(1'b1, 12'h128, 32'h8000_8000);
        pulse(6, 10, 40, 32'd10, "integer divide");
        wb(1'b1, 12'h12c, 32'h0001_0002);
        wb(1'b1, 12'h128, 32'h0300_0100);
        pulse(6, 10, 40, 32'd5, "fraction divide");
        wb(1'b1, 12'h128, 32'h0300_0200);
        pulse(0, 10, 8, 32'd8, "pin pick");
        wb(1'b1, 12'h128, 32'h0300_0300);
        pulse(2, 10, 8, 32'd8, "ref pick");
        wb(1'b1, 12'h128, 32'h1300_1000);
        pulse(2, 10, 8, 32'd8, "output pick");
        $display("test audio2 done");
    endtask : t_audio2

    task automatic t_misc;
        wb(1'b1, 12'h160, 32'h8000_8000);
        pulse(6, 0, 16, 32'd2, "pulse width");
        pulse(7, 4, 10, 32'd2, "crypto");
        pulse(7, 3, 10, 32'd2, "stream");
        pulse(5, 5, 32, 32'd2, "mic");
        wb(1'b1, 12'h138, 32'h3000_2000);
        pulse(4, 6, 16, 32'd2, "serial usb");
        wb(1'b1, 12'h158, 32'h03ff_0003);
        wb(1'b1, 12'h15c, 32'h03ff_0001);
        pulse(3, 2, 8, 32'd2, "thermal");
        pulse(3, 1, 8, 32'd4, "approx");
        wb(1'b1, 12'h138, 32'h0300_0200);
        pulse(3, 6, 8, 32'd8, "serial osc");
        wb(1'b1, 12'h140, 32'h0300_0300);
        wb(1'b1, 12'h148, 32'h0300_0200);
        pulse(3, 7, 8, 32'd8, "serial1 osc");
        pulse(3, 8, 8, 32'd8, "serial2 osc");
        for (int p = 2; p < 4; p++) begin
            wb(1'b1, 12'h130, 32'h0300_0000 | (32'(p) << 8));
            pulse(2, 9, 8, 32'd8, "digital ref");
        end
        $display("test misc done");
    endtask : t_misc

    // Audio port one: loop pick, integer divide, pin pick
    task automatic t_audio1;
        wb(1'b1, 12'h120, 32'h8300_8000);
        pulse(6, 11, 32, 32'd2, "audio1 general");
        wb(1'b1, 12'h120, 32'h0300_0200);
        pulse(1, 11, 8, 32'd8, "audio1 pin");
        $display("test audio1 done");
    endtask : t_audio1

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        src_tick = '0;
        n_fail = 0;
        n_tests = 0;
        mon_idx = 0;
        mon_cnt = 0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_mask();
        t_audio2();
        t_misc();
        t_audio1();
        finish_test();
    end
endmodule : pcsd_top_bench
